// *** hw/ila_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module ila_bank
  import ila_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  ila_reg_if.bank rif
);
  typedef struct packed {
    logic [31:0] c;
    logic [31:0] d;
  } ila_bank_st_t;
  ila_bank_st_t st_reg, st_next;

  // only field bits are stored; reserved bits never hold a one
  always_comb begin
    st_next = st_reg;
    if (rif.wr_c) begin
      st_next.c = rif.wdata & ILA_FIELD_MASK; // [R01] [R02] [R03] [R04] [R12]
    end
    if (rif.wr_d) begin
      st_next.d = rif.wdata & ILA_FIELD_MASK; // [R05] [R06] [R07] [R08] [R12]
    end
  end

  // every field comes up as level zero, all sources off
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0; // [R11]
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign rif.word_c = st_reg.c;
  assign rif.word_d = st_reg.d;

  chk_reserved_zero: assert property (@(posedge mclk) disable iff (rst) // [R12]
    ((st_reg.c & ~ILA_FIELD_MASK) == 32'h0) && ((st_reg.d & ~ILA_FIELD_MASK) == 32'h0))
    else $error("reserved bits hold a one");
  chk_write_lands: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (ce && rif.wr_c) |=> (st_reg.c == ($past(rif.wdata) & ILA_FIELD_MASK)))
    else $error("write to cfg_c did not land");
  chk_write_lands_d: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (ce && rif.wr_d) |=> (st_reg.d == ($past(rif.wdata) & ILA_FIELD_MASK)))
    else $error("write to cfg_d did not land");
endmodule
`default_nettype wire

// *** hw/ila_pkg.sv ***
package ila_pkg;
  localparam int ILA_AW = 16;
  localparam logic [ILA_AW-1:0] ILA_CFG_C_ADDR = 16'hF61C;
  localparam logic [ILA_AW-1:0] ILA_CFG_D_ADDR = 16'hF620;
  localparam int ILA_LW = 3;
  localparam int ILA_NSRC = 8;
  // field low bit positions, same layout in both registers
  localparam int ILA_F3_LSB = 24;
  localparam int ILA_F2_LSB = 16;
  localparam int ILA_F1_LSB = 8;
  localparam int ILA_F0_LSB = 0;
  localparam logic [ILA_LW-1:0] ILA_LVL_RESET = 3'h0;
  localparam logic [ILA_LW-1:0] ILA_LVL_OFF = 3'h0;
  localparam logic [31:0] ILA_FIELD_MASK = 32'h07070707;
  localparam logic [31:0] ILA_RD_ZERO = 32'h00000000;
  // level outputs index: source slot in the level vector
  localparam int ILA_S_EXT4 = 0;
  localparam int ILA_S_EXT5 = 1;
  localparam int ILA_S_PCI_ERROR_SOURCE_0 = 2;
  localparam int ILA_S_PCIPM0 = 3;
  localparam int ILA_S_SER0 = 4;
  localparam int ILA_S_SER1 = 5;
  localparam int ILA_S_AUDLINK = 6;
  localparam int ILA_S_AUDPM = 7;

  typedef enum logic [1:0] {ILA_SEL_NONE, ILA_SEL_C, ILA_SEL_D} ila_sel_t;

  // decode an APB byte address into a register select
  function automatic ila_sel_t ila_decode(input logic [ILA_AW-1:0] a);
    if (a == ILA_CFG_C_ADDR) begin
      return ILA_SEL_C;
    end else if (a == ILA_CFG_D_ADDR) begin
      return ILA_SEL_D;
    end
    return ILA_SEL_NONE;
  endfunction
endpackage

// *** hw/ila_reg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// write strobes and stored words between the bus slave and the register bank
interface ila_reg_if;
  logic wr_c;
  logic wr_d;
  logic [31:0] wdata;
  logic [31:0] word_c;
  logic [31:0] word_d;
  modport bus (output wr_c, output wr_d, output wdata, input word_c, input word_d);
  modport bank (input wr_c, input wr_d, input wdata, output word_c, output word_d);
endinterface
`default_nettype wire

// *** hw/ila_top.sv ***
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [R01] bits 26:24 of cfg_c hold the level of the pci power-management source 0.
// [R02] bits 18:16 of cfg_c hold the level of the pci error source 0.
// [R03] bits 10:8 of cfg_c hold the level of external pin 5.
// [R04] bits 2:0 of cfg_c hold the level of external pin 4 shared with ethernet 0.
// [R05] bits 26:24 of cfg_d hold the level of the audio-link power-management source.
// [R06] bits 18:16 of cfg_d hold the level of the audio-link general interrupt.
// [R07] bits 10:8 of cfg_d hold the level of serial port 1.
// [R08] bits 2:0 of cfg_d hold the level of serial port 0.
// [R09] a level of zero disables its source so it is never signalled.
// [R10] codes one to seven give levels one to seven, value equal to level.
// [R11] all fields reset to zero and are read-write at any time afterwards.
// [R12] reserved bits read as zero and ignore writes.
module ila_top
  import ila_pkg::*;
#(
  parameter int NSRC = ILA_NSRC
)(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ILA_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NSRC*ILA_LW-1:0] src_level,
  output logic [NSRC-1:0] src_enable
);
  ila_reg_if rif();

  ila_bank u_bank (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .rif(rif)
  );

  typedef struct packed {
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [NSRC*ILA_LW-1:0] lvl;
    logic [NSRC-1:0] en;
  } ila_top_st_t;
  ila_top_st_t st_reg, st_next;

  logic setup;
  logic access;
  ila_sel_t sel;
  logic [NSRC*ILA_LW-1:0] lvl_now;

  // pick one source's level out of a packed level vector
  function automatic logic [ILA_LW-1:0] slot_lvl(input logic [NSRC*ILA_LW-1:0] v,
                                                  input int s);
    return v[s*ILA_LW +: ILA_LW];
  endfunction

  // a transfer is answered in the first cycle of the access phase, so pready is a flop
  assign setup = psel && !penable;
  assign access = psel && penable && st_reg.ready;
  assign sel = ila_decode(paddr);

  // write strobes fire only at the completing edge; any nonzero pstrb writes the whole word,
  // since partial lanes would split a field pair from its neighbour
  assign rif.wr_c = ce && access && pwrite && (sel == ILA_SEL_C) && (pstrb != 4'h0);
  assign rif.wr_d = ce && access && pwrite && (sel == ILA_SEL_D) && (pstrb != 4'h0);
  assign rif.wdata = pwdata;

  // gather the stored fields into the per-source level vector
  always_comb begin
    lvl_now = '0;
    lvl_now[ILA_S_EXT4*ILA_LW +: ILA_LW] = rif.word_c[ILA_F0_LSB +: ILA_LW]; // [R04]
    lvl_now[ILA_S_EXT5*ILA_LW +: ILA_LW] = rif.word_c[ILA_F1_LSB +: ILA_LW]; // [R03]
    lvl_now[ILA_S_PCI_ERROR_SOURCE_0*ILA_LW +: ILA_LW] = rif.word_c[ILA_F2_LSB +: ILA_LW]; // [R02]
    lvl_now[ILA_S_PCIPM0*ILA_LW +: ILA_LW] = rif.word_c[ILA_F3_LSB +: ILA_LW]; // [R01]
    lvl_now[ILA_S_SER0*ILA_LW +: ILA_LW] = rif.word_d[ILA_F0_LSB +: ILA_LW]; // [R08]
    lvl_now[ILA_S_SER1*ILA_LW +: ILA_LW] = rif.word_d[ILA_F1_LSB +: ILA_LW]; // [R07]
    lvl_now[ILA_S_AUDLINK*ILA_LW +: ILA_LW] = rif.word_d[ILA_F2_LSB +: ILA_LW]; // [R06]
    lvl_now[ILA_S_AUDPM*ILA_LW +: ILA_LW] = rif.word_d[ILA_F3_LSB +: ILA_LW]; // [R05]
  end

  // bus answer and level outputs, all registered
  always_comb begin
    st_next = st_reg;
    st_next.ready = setup;
    st_next.err = 1'b0;
    if (setup) begin
      st_next.err = (sel == ILA_SEL_NONE);
      case (sel)
        ILA_SEL_C: st_next.rdata = rif.word_c; // [R12]
        ILA_SEL_D: st_next.rdata = rif.word_d; // [R12]
        default: st_next.rdata = ILA_RD_ZERO;
      endcase
    end else if (access) begin
      st_next.rdata = ILA_RD_ZERO;
    end
    // level value passes straight through as the level number
    st_next.lvl = lvl_now; // [R10]
    for (int i = 0; i < NSRC; i++) begin
      st_next.en[i] = (slot_lvl(lvl_now, i) != ILA_LVL_OFF); // [R09]
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= '0; // [R11]
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign src_level = st_reg.lvl;
  assign src_enable = st_reg.en;

  // a source at level zero must never be flagged live, one check per slot
  chk_ext4_off: assert property (@(posedge mclk) disable iff (rst) // [R09]
    (slot_lvl(src_level, ILA_S_EXT4) == ILA_LVL_OFF) |-> !src_enable[ILA_S_EXT4])
    else $error("ext pin4 enabled at level zero");
  chk_ext5_off: assert property (@(posedge mclk) disable iff (rst) // [R09]
    (slot_lvl(src_level, ILA_S_EXT5) == ILA_LVL_OFF) |-> !src_enable[ILA_S_EXT5])
    else $error("ext pin5 enabled at level zero");
  chk_pcierr_off: assert property (@(posedge mclk) disable iff (rst) // [R09]
    (slot_lvl(src_level, ILA_S_PCI_ERROR_SOURCE_0) == ILA_LVL_OFF) |-> !src_enable[ILA_S_PCI_ERROR_SOURCE_0])
    else $error("pci err enabled at level zero");
  chk_pcipm_off: assert property (@(posedge mclk) disable iff (rst) // [R09]
    (slot_lvl(src_level, ILA_S_PCIPM0) == ILA_LVL_OFF) |-> !src_enable[ILA_S_PCIPM0])
    else $error("pci pm enabled at level zero");
  chk_zero_disables: assert property (@(posedge mclk) disable iff (rst) // [R09]
    (slot_lvl(src_level, ILA_S_SER0) == ILA_LVL_OFF) |-> !src_enable[ILA_S_SER0])
    else $error("level zero source enabled");
  chk_ser1_off: assert property (@(posedge mclk) disable iff (rst) // [R09]
    (slot_lvl(src_level, ILA_S_SER1) == ILA_LVL_OFF) |-> !src_enable[ILA_S_SER1])
    else $error("serial1 enabled at level zero");
  chk_audlink_off: assert property (@(posedge mclk) disable iff (rst) // [R09]
    (slot_lvl(src_level, ILA_S_AUDLINK) == ILA_LVL_OFF) |-> !src_enable[ILA_S_AUDLINK])
    else $error("audio link enabled at level zero");
  chk_audpm_off: assert property (@(posedge mclk) disable iff (rst) // [R09]
    (slot_lvl(src_level, ILA_S_AUDPM) == ILA_LVL_OFF) |-> !src_enable[ILA_S_AUDPM])
    else $error("audio pm enabled at level zero");

  // any code from one to seven is a live level, again per slot
  chk_ext4_on: assert property (@(posedge mclk) disable iff (rst) // [R10]
    (slot_lvl(src_level, ILA_S_EXT4) != ILA_LVL_OFF) |-> src_enable[ILA_S_EXT4])
    else $error("ext pin4 disabled at nonzero level");
  chk_ext5_on: assert property (@(posedge mclk) disable iff (rst) // [R10]
    (slot_lvl(src_level, ILA_S_EXT5) != ILA_LVL_OFF) |-> src_enable[ILA_S_EXT5])
    else $error("ext pin5 disabled at nonzero level");
  chk_pcierr_on: assert property (@(posedge mclk) disable iff (rst) // [R10]
    (slot_lvl(src_level, ILA_S_PCI_ERROR_SOURCE_0) != ILA_LVL_OFF) |-> src_enable[ILA_S_PCI_ERROR_SOURCE_0])
    else $error("pci err disabled at nonzero level");
  chk_nonzero_enables: assert property (@(posedge mclk) disable iff (rst) // [R10]
    (slot_lvl(src_level, ILA_S_PCIPM0) != ILA_LVL_OFF) |-> src_enable[ILA_S_PCIPM0])
    else $error("nonzero level source disabled");
  chk_ser0_on: assert property (@(posedge mclk) disable iff (rst) // [R10]
    (slot_lvl(src_level, ILA_S_SER0) != ILA_LVL_OFF) |-> src_enable[ILA_S_SER0])
    else $error("serial0 disabled at nonzero level");
  chk_ser1_on: assert property (@(posedge mclk) disable iff (rst) // [R10]
    (slot_lvl(src_level, ILA_S_SER1) != ILA_LVL_OFF) |-> src_enable[ILA_S_SER1])
    else $error("serial1 disabled at nonzero level");
  chk_audlink_on: assert property (@(posedge mclk) disable iff (rst) // [R10]
    (slot_lvl(src_level, ILA_S_AUDLINK) != ILA_LVL_OFF) |-> src_enable[ILA_S_AUDLINK])
    else $error("audio link disabled at nonzero level");
  chk_audpm_on: assert property (@(posedge mclk) disable iff (rst) // [R10]
    (slot_lvl(src_level, ILA_S_AUDPM) != ILA_LVL_OFF) |-> src_enable[ILA_S_AUDPM])
    else $error("audio pm disabled at nonzero level");

  // each field takes its own write data bits at the completing edge
  chk_pcipm_store: assert property (@(posedge mclk) disable iff (rst) // [R01]
    rif.wr_c |=> (rif.word_c[ILA_F3_LSB +: ILA_LW] == $past(pwdata[ILA_F3_LSB +: ILA_LW])))
    else $error("pci pm field not stored");
  chk_pcierr_store: assert property (@(posedge mclk) disable iff (rst) // [R02]
    rif.wr_c |=> (rif.word_c[ILA_F2_LSB +: ILA_LW] == $past(pwdata[ILA_F2_LSB +: ILA_LW])))
    else $error("pci err field not stored");
  chk_ext5_store: assert property (@(posedge mclk) disable iff (rst) // [R03]
    rif.wr_c |=> (rif.word_c[ILA_F1_LSB +: ILA_LW] == $past(pwdata[ILA_F1_LSB +: ILA_LW])))
    else $error("ext pin5 field not stored");
  chk_ext4_store: assert property (@(posedge mclk) disable iff (rst) // [R04]
    rif.wr_c |=> (rif.word_c[ILA_F0_LSB +: ILA_LW] == $past(pwdata[ILA_F0_LSB +: ILA_LW])))
    else $error("ext pin4 field not stored");
  chk_audpm_store: assert property (@(posedge mclk) disable iff (rst) // [R05]
    rif.wr_d |=> (rif.word_d[ILA_F3_LSB +: ILA_LW] == $past(pwdata[ILA_F3_LSB +: ILA_LW])))
    else $error("audio pm field not stored");
  chk_audlink_store: assert property (@(posedge mclk) disable iff (rst) // [R06]
    rif.wr_d |=> (rif.word_d[ILA_F2_LSB +: ILA_LW] == $past(pwdata[ILA_F2_LSB +: ILA_LW])))
    else $error("audio link field not stored");
  chk_ser1_store: assert property (@(posedge mclk) disable iff (rst) // [R07]
    rif.wr_d |=> (rif.word_d[ILA_F1_LSB +: ILA_LW] == $past(pwdata[ILA_F1_LSB +: ILA_LW])))
    else $error("serial1 field not stored");
  chk_ser0_store: assert property (@(posedge mclk) disable iff (rst) // [R08]
    rif.wr_d |=> (rif.word_d[ILA_F0_LSB +: ILA_LW] == $past(pwdata[ILA_F0_LSB +: ILA_LW])))
    else $error("serial0 field not stored");

  // the level outputs trail the stored fields by one enabled edge
  chk_pcipm_field: assert property (@(posedge mclk) disable iff (rst) // [R01]
    ce |=> slot_lvl(src_level, ILA_S_PCIPM0) == $past(rif.word_c[ILA_F3_LSB +: ILA_LW]))
    else $error("pci pm level mismatch");
  chk_pcierr_field: assert property (@(posedge mclk) disable iff (rst) // [R02]
    ce |=> slot_lvl(src_level, ILA_S_PCI_ERROR_SOURCE_0) == $past(rif.word_c[ILA_F2_LSB +: ILA_LW]))
    else $error("pci err level mismatch");
  chk_ext5_field: assert property (@(posedge mclk) disable iff (rst) // [R03]
    ce |=> slot_lvl(src_level, ILA_S_EXT5) == $past(rif.word_c[ILA_F1_LSB +: ILA_LW]))
    else $error("ext pin5 level mismatch");
  chk_ext4_field: assert property (@(posedge mclk) disable iff (rst) // [R04]
    ce |=> slot_lvl(src_level, ILA_S_EXT4) == $past(rif.word_c[ILA_F0_LSB +: ILA_LW]))
    else $error("ext pin4 level mismatch");
  chk_audpm_field: assert property (@(posedge mclk) disable iff (rst) // [R05]
    ce |=> slot_lvl(src_level, ILA_S_AUDPM) == $past(rif.word_d[ILA_F3_LSB +: ILA_LW]))
    else $error("audio pm level mismatch");
  chk_audlink_field: assert property (@(posedge mclk) disable iff (rst) // [R06]
    ce |=> slot_lvl(src_level, ILA_S_AUDLINK) == $past(rif.word_d[ILA_F2_LSB +: ILA_LW]))
    else $error("audio link level mismatch");
  chk_ser1_field: assert property (@(posedge mclk) disable iff (rst) // [R07]
    ce |=> slot_lvl(src_level, ILA_S_SER1) == $past(rif.word_d[ILA_F1_LSB +: ILA_LW]))
    else $error("serial1 level mismatch");
  chk_ser0_field: assert property (@(posedge mclk) disable iff (rst) // [R08]
    ce |=> slot_lvl(src_level, ILA_S_SER0) == $past(rif.word_d[ILA_F0_LSB +: ILA_LW]))
    else $error("serial0 level mismatch");

  // bus answer: data, error and ready behave as one registered pulse
  chk_read_reserved: assert property (@(posedge mclk) disable iff (rst) // [R12]
    (pready && psel && penable && !pwrite) |-> ((prdata & ~ILA_FIELD_MASK) == 32'h0))
    else $error("reserved read bits nonzero");
  chk_ready_pulse: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (ce && psel && !penable) |=> pready ##1 (!pready || !$past(ce)))
    else $error("pready timing wrong");
  chk_read_c_word: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (ce && psel && !penable && !pwrite && (paddr == ILA_CFG_C_ADDR))
      |=> (prdata == $past(rif.word_c)))
    else $error("cfg_c read data wrong");
  chk_read_d_word: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (ce && psel && !penable && !pwrite && (paddr == ILA_CFG_D_ADDR))
      |=> (prdata == $past(rif.word_d)))
    else $error("cfg_d read data wrong");
  chk_unmapped_err: assert property (@(posedge mclk) disable iff (rst) // [R12]
    (ce && psel && !penable && (ila_decode(paddr) == ILA_SEL_NONE))
      |=> (pslverr && (prdata == ILA_RD_ZERO)))
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (ce && psel && !penable && (ila_decode(paddr) != ILA_SEL_NONE)) |=> !pslverr)
    else $error("mapped access flagged as error");
  chk_err_ready: assert property (@(posedge mclk) disable iff (rst) // [R11]
    pslverr |-> pready)
    else $error("error without ready");
  chk_idle_zero: assert property (@(posedge mclk) disable iff (rst) // [R12]
    !pready |-> (prdata == ILA_RD_ZERO))
    else $error("read data outside the answer cycle");

  // stored words move only on a completed write with a nonzero strobe to their address
  chk_write_access: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (rif.wr_c || rif.wr_d) |-> (psel && penable && pwrite && pready))
    else $error("write strobe outside the access phase");
  chk_empty_strobe: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (pstrb == 4'h0) |-> !(rif.wr_c || rif.wr_d))
    else $error("write with empty strobe");
  chk_unmapped_nowrite: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (ila_decode(paddr) == ILA_SEL_NONE) |-> !(rif.wr_c || rif.wr_d))
    else $error("write strobe for unmapped address");
  chk_word_hold: assert property (@(posedge mclk) disable iff (rst) // [R11]
    (ce && !rif.wr_c && !rif.wr_d) |=> ($stable(rif.word_c) && $stable(rif.word_d)))
    else $error("stored word changed without a write");

  // a low enable freezes every register, so nothing visible may move
  chk_ce_freeze: assert property (@(posedge mclk) disable iff (rst) // [R11]
    !ce |=> ($stable(src_level) && $stable(src_enable) && $stable(pready)
      && $stable(rif.word_c) && $stable(rif.word_d)))
    else $error("state moved while enable low");

  // reset seen at the last edge leaves every output and both words at zero
  chk_reset_quiet: assert property (@(posedge mclk) // [R11]
    $past(rst) |-> ((src_level == '0) && (src_enable == '0) && !pready && !pslverr
      && (prdata == ILA_RD_ZERO) && (rif.word_c == '0) && (rif.word_d == '0)))
    else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// *** tb/irq_level_assign_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_level_assign_regs_tb
  import ila_pkg::*;
;
  logic mclk, rst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [ILA_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, wc, wd;
  logic [3:0] pstrb;
  logic [23:0] src_level;
  logic [7:0] src_enable;
  int err_total, cmp_count;

  ila_top dut (.mclk(mclk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_level(src_level), .src_enable(src_enable));

  // 100 mhz clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one apb transfer; a missing pready counts as a mismatch instead of hanging
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      $display("FAIL pready expected 1 seen %b", pready);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // expected level vector, slot 0 in the low bits
  function automatic logic [23:0] lvl(input logic [31:0] c, input logic [31:0] d);
    return {d[26:24], d[18:16], d[10:8], d[2:0], c[26:24], c[18:16], c[10:8], c[2:0]};
  endfunction

  // a source is live only when its level is nonzero
  function automatic logic [7:0] en(input logic [23:0] l);
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      e[i] = (l[3*i+:3] != 3'h0);
    end
    return e;
  endfunction

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    err_total = 0;
    cmp_count = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, ILA_CFG_C_ADDR, 32'h0, rd, err);
    chk("cfg_c reset", 32'h0, rd);
    apb(1'b0, ILA_CFG_D_ADDR, 32'h0, rd, err);
    chk("cfg_d reset", 32'h0, rd);
    chk("level reset", 32'h0, {src_enable, src_level});
    $display("test reset done");
    // every code reaches every field; reserved bits are always written as ones
    for (int v = 0; v < 8; v++) begin
      wc = {5'h1F, 3'(v), 5'h1F, 3'(v + 1), 5'h1F, 3'(v + 2), 5'h1F, 3'(v + 3)};
      wd = {5'h1F, 3'(v + 4), 5'h1F, 3'(v + 5), 5'h1F, 3'(v + 6), 5'h1F, 3'(v + 7)};
      apb(1'b1, ILA_CFG_C_ADDR, wc, rd, err);
      chk("cfg_c write error", 32'h0, {31'h0, err});
      apb(1'b1, ILA_CFG_D_ADDR, wd, rd, err);
      apb(1'b0, ILA_CFG_C_ADDR, 32'h0, rd, err);
      chk("cfg_c read", wc & 32'h07070707, rd);
      apb(1'b0, ILA_CFG_D_ADDR, 32'h0, rd, err);
      chk("cfg_d read", wd & 32'h07070707, rd);
      chk("src_level", {8'h0, lvl(wc, wd)}, {8'h0, src_level});
      chk("src_enable", {24'h0, en(lvl(wc, wd))}, {24'h0, src_enable});
    end
    $display("test field map done");
    // unmapped place and empty strobe must leave both words as they are
    apb(1'b1, 16'hF624, 32'h07070707, rd, err);
    chk("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, 16'hF624, 32'h0, rd, err);
    chk("unmapped read", 32'h0, rd);
    chk("unmapped read error", 32'h1, {31'h0, err});
    pstrb <= 4'h0;
    apb(1'b1, ILA_CFG_C_ADDR, 32'h0, rd, err);
    pstrb <= 4'hF;
    apb(1'b0, ILA_CFG_C_ADDR, 32'h0, rd, err);
    chk("cfg_c kept", wc & 32'h07070707, rd);
    apb(1'b0, ILA_CFG_D_ADDR, 32'h0, rd, err);
    chk("cfg_d kept", wd & 32'h07070707, rd);
    $display("test refusal done");
    // the write lands, then the enable drops before the level outputs follow
    apb(1'b1, ILA_CFG_C_ADDR, 32'h00000005, rd, err);
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("frozen level", {8'h0, lvl(wc, wd)}, {8'h0, src_level});
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("thawed level", {8'h0, lvl(32'h00000005, wd)}, {8'h0, src_level});
    chk("thawed enable", {24'h0, en(lvl(32'h00000005, wd))}, {24'h0, src_enable});
    $display("test enable freeze done");
    // a second reset in mid-run clears both words and the level outputs
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b0, ILA_CFG_C_ADDR, 32'h0, rd, err);
    chk("cfg_c after reset", 32'h0, rd);
    apb(1'b0, ILA_CFG_D_ADDR, 32'h0, rd, err);
    chk("cfg_d after reset", 32'h0, rd);
    chk("level after reset", 32'h0, {src_enable, src_level});
    $display("test second reset done");
    test_done();
  end
endmodule
`default_nettype wire
